// >>> mpl_top.sv
// mpl_top: mii receive/transmit timing path and 10base-t link timers,
// with the receive symbol fifo.
// assumes every line and mii input is asynchronous to clk_sys_in.
`timescale 1ns/100ps

module mpl_fifo
    import mpl_pkg::*;
#(
    parameter int W = 5,
    parameter int D = FIFO_DEPTH
) (
    input wire logic clk_sys_in, // system clock
    input wire logic reset_in, // async reset, high
    input wire logic flush_in, // drop all words
    input wire logic in_valid_in, // write request
    output logic in_ready_out, // room for a word
    input wire logic [W-1:0] in_data_in, // write data
    output logic out_valid_out, // word available
    input wire logic out_ready_in, // read accept
    output logic [W-1:0] out_data_out // head word
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic wr_en, rd_en;

    always_comb begin
        in_ready_out = (cnt_reg != (AW+1)'(D));
        out_valid_out = (cnt_reg != '0);
        wr_en = in_valid_in && in_ready_out && !flush_in;
        rd_en = out_valid_out && out_ready_in && !flush_in;
        wr_next = wr_reg;
        rd_next = rd_reg;
        cnt_next = cnt_reg;
        if (flush_in) begin
            wr_next = '0;
            rd_next = '0;
            cnt_next = '0;
        end else begin
            if (wr_en) begin
                wr_next = (wr_reg == AW'(D-1)) ? '0 : wr_reg + 1'b1;
            end
            if (rd_en) begin
                rd_next = (rd_reg == AW'(D-1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_next = cnt_reg + (AW+1)'(wr_en) - (AW+1)'(rd_en);
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (wr_en) begin
            mem[wr_reg] <= in_data_in;
        end
    end

    assign out_data_out = mem[rd_reg];
endmodule : mpl_fifo

module mpl_top
    import mpl_pkg::*;
#(
    parameter int LINK_MIN = LINK_MIN_CYC, // shortest pulse gap, cycles
    parameter int LINK_MAX = LINK_MAX_CYC, // longest pulse gap, cycles
    parameter int LINK_LOSS = LINK_LOSS_CYC // loss window, cycles
) (
    input wire logic clk_sys_in, // 100 MHz system clock
    input wire logic reset_in, // async reset, high
    input wire logic sym_mode_in, // 1: 5-bit symbol mode
    input wire logic repeater_mode_in, // 1: repeater mode
    input wire logic line_j_start_in, // start of J delimiter
    input wire logic line_t_start_in, // start of T delimiter
    input wire logic line_rx_strobe_in, // receive symbol strobe
    input wire logic [4:0] line_receive_input_in, // receive code group
    input wire logic line_link_pulse_in, // 10base-t link pulse
    input wire logic output_float_control_in, // receive output float
    input wire logic mii_tx_clk_in, // mii transmit clock
    input wire logic mii_tx_en_in, // mii transmit enable
    input wire logic mii_tx_er_in, // symbol bit 4 in 5-bit mode
    input wire logic [3:0] mii_txd_in, // mii transmit data
    output logic mii_crs_out, // carrier sense
    output logic mii_col_out, // collision
    output logic mii_rx_dv_out, // receive data valid
    output logic [4:0] mii_rxd_out, // receive data or symbol
    output logic mii_rx_oe_n_out, // receive output enable, low
    output logic [4:0] line_transmit_output_out, // transmit code group
    output logic line_tx_en_out, // transmit active on line
    output logic line_rx_ready_out, // receive fifo has room
    output logic link_up_out // 10base-t link good
);
    // -----------------------------------------------------------------
    // input synchronisers
    // -----------------------------------------------------------------
    mpl_pins_t pins, s1_reg, s1_next, s2_reg, s2_next, s3_reg, s3_next;
    logic j_e, t_e, strobe_e, tx_samp, pulse_e;

    always_comb begin
        pins = '{sym_mode: sym_mode_in, repeater: repeater_mode_in,
                 j: line_j_start_in, t: line_t_start_in,
                 strobe: line_rx_strobe_in, sym: line_receive_input_in,
                 tx_clk: mii_tx_clk_in, tx_en: mii_tx_en_in,
                 tx_er: mii_tx_er_in, txd: mii_txd_in,
                 pulse: line_link_pulse_in,
                 float_ctl: output_float_control_in};
        s1_next = pins;
        s2_next = s1_reg;
        s3_next = s2_reg;
        j_e = s2_reg.j && !s3_reg.j;
        t_e = s2_reg.t && !s3_reg.t;
        strobe_e = s2_reg.strobe && !s3_reg.strobe;
        tx_samp = s2_reg.tx_clk && !s3_reg.tx_clk;
        pulse_e = s2_reg.pulse && !s3_reg.pulse;
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
        end
    end

    // -----------------------------------------------------------------
    // receive timing and data
    // -----------------------------------------------------------------
    logic frame_reg, frame_next, crs_rx_reg, crs_rx_next;
    logic col_reg, col_next, dv_reg, dv_next, win_reg, win_next;
    logic [RX_FALL_TAP:0] rxh_reg, rxh_next;
    logic [DV_TAP:0] crsh_reg, crsh_next;
    logic [4:0] rxd_reg, rxd_next, fifo_data;
    logic fifo_valid, pop, tx_on;
    logic [4:0] tsince_reg, tsince_next;

    always_comb begin
        frame_next = j_e ? 1'b1 : (t_e ? 1'b0 : frame_reg);
        // helper for the checks: cycles since the last T edge, saturating
        tsince_next = t_e ? '0 : tsince_reg + 5'(tsince_reg != '1);
        rxh_next = {rxh_reg[RX_FALL_TAP-1:0], frame_reg};
        // fall tap holds carrier while the late end of the frame drains;
        // the rise tap keeps it up until the fall tap has filled
        crs_rx_next = rxh_reg[RX_RISE_TAP]
                      || (crs_rx_reg && rxh_reg[RX_FALL_TAP]);
        col_next = tx_on && (rxh_reg[RX_RISE_TAP]
                   || (col_reg && rxh_reg[RX_FALL_TAP]));
        crsh_next = {crsh_reg[DV_TAP-1:0], crs_rx_reg};
        dv_next = crsh_reg[DV_TAP];
        win_next = s2_reg.sym_mode ? crsh_reg[RXD5_TAP]
                                   : crsh_reg[DV_TAP];
        pop = win_reg && strobe_e && fifo_valid;
        rxd_next = rxd_reg;
        if (!win_reg) begin
            rxd_next = SYM_IDLE;
        end else if (pop) begin
            rxd_next = s2_reg.sym_mode ? fifo_data
                                       : {1'b0, mpl_dec(fifo_data)};
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            frame_reg <= 1'b0;
            tsince_reg <= '1;
            rxh_reg <= '0;
            crs_rx_reg <= 1'b0;
            col_reg <= 1'b0;
            crsh_reg <= '0;
            dv_reg <= 1'b0;
            win_reg <= 1'b0;
            rxd_reg <= SYM_IDLE;
        end else begin
            frame_reg <= frame_next;
            tsince_reg <= tsince_next;
            rxh_reg <= rxh_next;
            crs_rx_reg <= crs_rx_next;
            col_reg <= col_next;
            crsh_reg <= crsh_next;
            dv_reg <= dv_next;
            win_reg <= win_next;
            rxd_reg <= rxd_next;
        end
    end

    // symbols wait here until the output window opens; a new J drops
    // whatever an aborted frame left behind
    mpl_fifo #(.W(5), .D(FIFO_DEPTH)) u_rx_fifo (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .flush_in(j_e),
        .in_valid_in(frame_reg && strobe_e),
        .in_ready_out(line_rx_ready_out),
        .in_data_in(s2_reg.sym),
        .out_valid_out(fifo_valid),
        .out_ready_in(pop),
        .out_data_out(fifo_data)
    );

    // -----------------------------------------------------------------
    // transmit timing and data
    // -----------------------------------------------------------------
    logic ten_reg, ten_next, crs_tx_reg, crs_tx_next;
    logic [TX_OFF_TAP:0] txh_reg, txh_next;
    mpl_txsym_t tsym_reg, tsym_next, tout_reg, tout_next;
    mpl_txsym_t [TX4_TAP:0] tpipe_reg, tpipe_next;

    always_comb begin
        tx_on = ten_reg;
        ten_next = tx_samp ? s2_reg.tx_en : ten_reg;
        tsym_next = tsym_reg;
        if (tx_samp) begin
            tsym_next.en = s2_reg.tx_en;
            tsym_next.sym = s2_reg.sym_mode ? {s2_reg.tx_er, s2_reg.txd}
                                            : mpl_enc(s2_reg.txd);
        end
        txh_next = {txh_reg[TX_OFF_TAP-1:0], ten_reg};
        crs_tx_next = crs_tx_reg ? txh_reg[TX_OFF_TAP]
                                 : txh_reg[TX_ON_TAP];
        tpipe_next = {tpipe_reg[TX4_TAP-1:0], tsym_reg};
        tout_next = s2_reg.sym_mode ? tpipe_reg[TX5_TAP]
                                    : tpipe_reg[TX4_TAP];
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            ten_reg <= 1'b0;
            tsym_reg <= '0;
            txh_reg <= '0;
            crs_tx_reg <= 1'b0;
            tpipe_reg <= '0;
            tout_reg <= '0;
        end else begin
            ten_reg <= ten_next;
            tsym_reg <= tsym_next;
            txh_reg <= txh_next;
            crs_tx_reg <= crs_tx_next;
            tpipe_reg <= tpipe_next;
            tout_reg <= tout_next;
        end
    end

    // -----------------------------------------------------------------
    // link integrity
    // -----------------------------------------------------------------
    logic [LINK_TW-1:0] tmr_reg, tmr_next;
    logic link_reg, link_next, early;

    always_comb begin
        early = tmr_reg < LINK_TW'(LINK_MIN);
        tmr_next = tmr_reg;
        link_next = link_reg;
        // saturate one past the maximum so a late pulse is still seen late
        if (tmr_reg <= LINK_TW'(LINK_MAX)) begin
            tmr_next = tmr_reg + 1'b1;
        end
        if (tmr_reg >= LINK_TW'(LINK_LOSS)) begin
            link_next = 1'b0;
        end
        if (pulse_e && !early) begin
            tmr_next = TIMER_RST;
            link_next = tmr_reg <= LINK_TW'(LINK_MAX);
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            tmr_reg <= TIMER_RST;
            link_reg <= 1'b0;
        end else begin
            tmr_reg <= tmr_next;
            link_reg <= link_next;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign mii_crs_out = crs_rx_reg || crs_tx_reg;
    assign mii_col_out = col_reg;
    assign mii_rx_dv_out = dv_reg;
    assign mii_rxd_out = rxd_reg;
    // float control passes only the two sync stages, 20 ns
    assign mii_rx_oe_n_out = s2_reg.repeater && !s2_reg.float_ctl;
    assign line_transmit_output_out = tout_reg.sym;
    assign line_tx_en_out = tout_reg.en;
    assign link_up_out = link_reg;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);

    property p_loss;
        link_reg && tmr_reg > LINK_TW'(LINK_LOSS) |=> !link_reg;
    endproperty
    a_loss: assert property (p_loss) else $error("link not lost");
    property p_early;
        pulse_e && early |=> link_reg == $past(link_reg) && tmr_reg != '0;
    endproperty
    a_early: assert property (p_early) else $error("early pulse used");
    property p_late;
        pulse_e && tmr_reg > LINK_TW'(LINK_MAX) |=> !link_reg;
    endproperty
    a_late: assert property (p_late) else $error("late pulse taken");
    property p_dv;
        $rose(crs_rx_reg) |-> ##8 $rose(dv_reg);
    endproperty
    a_dv: assert property (p_dv) else $error("rx_dv latency");
    property p_crs_j;
        j_e && !frame_reg && !crs_rx_reg ##1 frame_reg[*8]
            |-> ##[1:10] $rose(crs_rx_reg);
    endproperty
    a_crs_j: assert property (p_crs_j) else $error("crs late");
    property p_crs_t;
        t_e && crs_rx_reg |-> ##[11:27] !crs_rx_reg;
    endproperty
    a_crs_t: assert property (p_crs_t) else $error("crs end");
    // a counter instead of a long repetition keeps the checker small
    property p_crs_min;
        $fell(crs_rx_reg) |-> tsince_reg >= 5'h0a;
    endproperty
    a_crs_min: assert property (p_crs_min) else $error("crs soon");
    property p_col;
        col_reg |-> crs_rx_reg || $past(crs_rx_reg);
    endproperty
    a_col: assert property (p_col) else $error("col without rx");
    property p_col_t;
        t_e && col_reg |-> ##[1:28] !col_reg;
    endproperty
    a_col_t: assert property (p_col_t) else $error("col stuck");
    property p_sym5;
        $rose(crs_rx_reg) && s2_reg.sym_mode |-> ##4 $rose(win_reg);
    endproperty
    a_sym5: assert property (p_sym5) else $error("5b rxd latency");
    property p_txcrs;
        tx_samp && s2_reg.tx_en && !ten_reg |-> ##[1:4] mii_crs_out;
    endproperty
    a_txcrs: assert property (p_txcrs) else $error("tx crs late");
    property p_txoff;
        tx_samp && !s2_reg.tx_en && ten_reg |-> ##[1:16] !crs_tx_reg;
    endproperty
    a_txoff: assert property (p_txoff) else $error("tx crs stuck");
    property p_txlat;
        tx_samp && s2_reg.tx_en && !ten_reg && s2_reg.sym_mode
            |-> !line_tx_en_out[*4] ##[1:5] line_tx_en_out;
    endproperty
    a_txlat: assert property (p_txlat) else $error("tx latency");

    c_frame: cover property ($fell(dv_reg) ##[1:40] $fell(crs_rx_reg));
    c_col: cover property ($rose(col_reg));
    c_link: cover property ($rose(link_reg));
    c_tx: cover property ($rose(line_tx_en_out));
endmodule : mpl_top

// >>> mpl_pkg.sv
// mpl_pkg: timing constants, pin bundles and 4b/5b code tables for the
// mii path and link timing block.
// assumes a 100 MHz system clock, so one 100 Mbps bit time is one cycle.
package mpl_pkg;
    // -----------------------------------------------------------------
    // clock and bit time
    // -----------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int BT_NS = 10;
    localparam int BT_CYC = BT_NS / CLK_NS;
    // -----------------------------------------------------------------
    // latencies in bit times, float delay in ns
    // -----------------------------------------------------------------
    localparam int CRS_J_BT = 16;
    localparam int CRS_T_BT = 24;
    localparam int DV_BT = 8;
    localparam int RXD5_BT = 4;
    localparam int TXCRS_ON_BT = 3;
    localparam int TXCRS_OFF_BT = 4;
    localparam int TXLAT5_BT = 6;
    localparam int TXLAT4_BT = 10;
    localparam int FLOAT_NS = 20;
    localparam int FLOAT_CYC = FLOAT_NS / CLK_NS;
    // pipeline stages already spent before a tap is reached
    localparam int RX_PIPE = 4;
    localparam int TX_PIPE = 3;
    localparam int CRS_DLY = 2;
    localparam int RX_RISE_TAP = CRS_J_BT * BT_CYC - RX_PIPE;
    localparam int RX_FALL_TAP = CRS_T_BT * BT_CYC - RX_PIPE;
    localparam int DV_TAP = DV_BT * BT_CYC - CRS_DLY;
    localparam int RXD5_TAP = RXD5_BT * BT_CYC - CRS_DLY;
    localparam int TX_ON_TAP = TXCRS_ON_BT * BT_CYC - TX_PIPE;
    localparam int TX_OFF_TAP = TXCRS_OFF_BT * BT_CYC - TX_PIPE;
    localparam int TX5_TAP = TXLAT5_BT * BT_CYC - TX_PIPE;
    localparam int TX4_TAP = TXLAT4_BT * BT_CYC - TX_PIPE;
    // -----------------------------------------------------------------
    // link integrity timers
    // -----------------------------------------------------------------
    localparam int LINK_MIN_MS = 4;
    localparam int LINK_MAX_MS = 64;
    localparam int LINK_LOSS_MS = 64;
    localparam int CYC_PER_MS = 1000000 / CLK_NS;
    localparam int LINK_MIN_CYC = LINK_MIN_MS * CYC_PER_MS;
    localparam int LINK_MAX_CYC = LINK_MAX_MS * CYC_PER_MS;
    localparam int LINK_LOSS_CYC = LINK_LOSS_MS * CYC_PER_MS;
    localparam int LINK_TW = 24;
    // -----------------------------------------------------------------
    // reset values and sizes
    // -----------------------------------------------------------------
    localparam logic [4:0] SYM_IDLE = 5'h00;
    localparam logic [LINK_TW-1:0] TIMER_RST = 24'h00_0000;
    localparam int FIFO_DEPTH = 32;

    typedef struct packed {
        logic sym_mode;
        logic repeater;
        logic j;
        logic t;
        logic strobe;
        logic [4:0] sym;
        logic tx_clk;
        logic tx_en;
        logic tx_er;
        logic [3:0] txd;
        logic pulse;
        logic float_ctl;
    } mpl_pins_t;

    typedef struct packed {
        logic en;
        logic [4:0] sym;
    } mpl_txsym_t;

    function automatic logic [4:0] mpl_enc(input logic [3:0] d);
        logic [4:0] s;
        case (d)
            4'h0: s = 5'h1e;
            4'h1: s = 5'h09;
            4'h2: s = 5'h14;
            4'h3: s = 5'h15;
            4'h4: s = 5'h0a;
            4'h5: s = 5'h0b;
            4'h6: s = 5'h0e;
            4'h7: s = 5'h0f;
            4'h8: s = 5'h12;
            4'h9: s = 5'h13;
            4'ha: s = 5'h16;
            4'hb: s = 5'h17;
            4'hc: s = 5'h1a;
            4'hd: s = 5'h1b;
            4'he: s = 5'h1c;
            default: s = 5'h1d;
        endcase
        return s;
    endfunction : mpl_enc

    // code groups outside the data set decode to zero
    function automatic logic [3:0] mpl_dec(input logic [4:0] s);
        logic [3:0] d;
        d = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (mpl_enc(4'(i)) == s) begin
                d = 4'(i);
            end
        end
        return d;
    endfunction : mpl_dec
endpackage : mpl_pkg

// >>> mpl_mac_model.sv
// mpl_mac_model: mac side of the mii transmit path for the bench.
// assumes the 100 MHz bench clock; makes a 160 ns transmit clock.
`timescale 1ns/100ps

module mpl_mac_model (
    input wire logic clk_in, // bench clock
    input wire logic reset_in, // async reset, high
    input wire logic start_in, // one-cycle frame request
    input wire logic [3:0] len_in, // nibbles in the frame
    output logic tx_clk_out, // transmit clock
    output logic tx_en_out, // transmit enable
    output logic tx_er_out, // symbol bit 4
    output logic [3:0] txd_out // transmit nibble
);
    logic [3:0] div_reg;
    logic [3:0] idx_reg;
    logic busy_reg;

    // data moves as the clock falls, half a period before it is sampled
    assign tx_clk_out = div_reg[3];

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            div_reg <= 4'h0;
            idx_reg <= 4'h0;
            busy_reg <= 1'b0;
            tx_en_out <= 1'b0;
            tx_er_out <= 1'b0;
            txd_out <= 4'h0;
        end else begin
            div_reg <= div_reg + 4'h1;
            if (div_reg == 4'hf) begin
                if (busy_reg && idx_reg < len_in) begin
                    tx_en_out <= 1'b1;
                    txd_out <= idx_reg + 4'h5;
                    tx_er_out <= idx_reg[0];
                    idx_reg <= idx_reg + 4'h1;
                end else begin
                    // idle lines toggle so a stale nibble never looks valid
                    tx_en_out <= 1'b0;
                    txd_out <= ~txd_out;
                    tx_er_out <= ~tx_er_out;
                    idx_reg <= 4'h0;
                    busy_reg <= 1'b0;
                end
            end
            if (start_in) begin
                busy_reg <= 1'b1;
            end
        end
    end
endmodule : mpl_mac_model

// >>> tb_mpl_top.sv
// tb_mpl_top: self-checking bench for the mii path and link timers.
// assumes mpl_top with link timers shortened to 20/200/200 cycles.
`timescale 1ns/100ps

module tb_mpl_top;
    localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15,
        5'h0a, 5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17,
        5'h1a, 5'h1b, 5'h1c, 5'h1d};
    logic clk, reset_in, sym_mode, repeater, j, t, strobe, pulse, flt;
    logic start, crs, col, dv, oe_n, ltx_en, rdy, link;
    logic tx_clk, tx_en, tx_er;
    logic [3:0] txd, len;
    logic [4:0] rx_sym, rxd, lto;
    int fail_count;
    int total_checks;

    mpl_mac_model mac (.clk_in(clk), .reset_in(reset_in),
        .start_in(start), .len_in(len), .tx_clk_out(tx_clk),
        .tx_en_out(tx_en), .tx_er_out(tx_er), .txd_out(txd));

    mpl_top #(.LINK_MIN(20), .LINK_MAX(200), .LINK_LOSS(200)) dut (
        .clk_sys_in(clk), .reset_in(reset_in), .sym_mode_in(sym_mode),
        .repeater_mode_in(repeater), .line_j_start_in(j),
        .line_t_start_in(t), .line_rx_strobe_in(strobe),
        .line_receive_input_in(rx_sym), .line_link_pulse_in(pulse),
        .output_float_control_in(flt), .mii_tx_clk_in(tx_clk),
        .mii_tx_en_in(tx_en), .mii_tx_er_in(tx_er), .mii_txd_in(txd),
        .mii_crs_out(crs), .mii_col_out(col), .mii_rx_dv_out(dv),
        .mii_rxd_out(rxd), .mii_rx_oe_n_out(oe_n),
        .line_transmit_output_out(lto), .line_tx_en_out(ltx_en),
        .line_rx_ready_out(rdy), .link_up_out(link));

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic conclude();
        if (fail_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [4:0] e,
                       input logic [4:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    function automatic logic sig(input int s);
        case (s)
            0: return crs;
            1: return col;
            2: return dv;
            3: return ltx_en;
            default: return oe_n;
        endcase
    endfunction : sig

    // counts clock edges until the output shows lvl, sampled mid-cycle
    task automatic wait_sig(input int s, input logic lvl, input int lim,
                            output int n);
        n = 0;
        while (sig(s) !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (sig(s) !== lvl) begin
            fail_count++;
            $display("[ERR] wait %0d expected %b seen timeout", s, lvl);
            conclude();
        end
    endtask : wait_sig

    task automatic send_sym(input logic [4:0] s);
        @(posedge clk);
        strobe <= 1'b1;
        rx_sym <= s;
        @(posedge clk);
        strobe <= 1'b0;
    endtask : send_sym

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic t_link();
        repeat (10) @(posedge clk);
        pulse <= 1'b1;
        @(posedge clk);
        pulse <= 1'b0;
        repeat (4) @(negedge clk);
        chk("link_early", 5'h00, 5'(link));
        repeat (40) @(posedge clk);
        pulse <= 1'b1;
        @(posedge clk);
        pulse <= 1'b0;
        repeat (4) @(negedge clk);
        chk("link_good", 5'h01, 5'(link));
        repeat (180) @(negedge clk);
        chk("link_hold", 5'h01, 5'(link));
        repeat (30) @(negedge clk);
        chk("link_lost", 5'h00, 5'(link));
        // gap now beyond the maximum receive time: pulse must not qualify
        @(posedge clk);
        pulse <= 1'b1;
        @(posedge clk);
        pulse <= 1'b0;
        repeat (4) @(negedge clk);
        chk("link_late", 5'h00, 5'(link));
    endtask : t_link

    task automatic t_tx(input logic m);
        int n;
        @(posedge clk);
        sym_mode <= m;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(negedge clk);
        wait_sig(0, 1'b1, 60, n);
        wait_sig(3, 1'b1, 20, n);
        chk("crs_to_line", m ? 5'h03 : 5'h07, 5'(n));
        chk("line_sym", m ? 5'h05 : ENC[5], lto);
        wait_sig(0, 1'b0, 120, n);
        wait_sig(3, 1'b0, 20, n);
        chk("crs_off_to_line_off", m ? 5'h02 : 5'h06, 5'(n));
        repeat (20) @(posedge clk);
    endtask : t_tx

    // c: a mac frame runs underneath, so collision is judged
    task automatic t_rx(input logic m, input logic c);
        int n;
        logic [4:0] s0;
        s0 = m ? 5'h19 : ENC[3];
        @(posedge clk);
        sym_mode <= m;
        len <= c ? 4'hf : 4'h4;
        start <= c;
        @(posedge clk);
        start <= 1'b0;
        repeat (40) @(posedge clk);
        j <= 1'b1;
        repeat (3) @(posedge clk);
        send_sym(s0);
        @(negedge clk);
        wait_sig(int'(c), 1'b1, 30, n);
        chk("j_to_crs", 5'h01, 5'(n + 5 <= 20));
        @(negedge clk);
        chk("crs_held", 5'h01, 5'(sig(int'(c))));
        wait_sig(2, 1'b1, 20, n);
        chk("crs_to_dv", 5'h08, 5'(n + 1));
        send_sym(ENC[9]);
        repeat (4) @(negedge clk);
        chk("rxd_first", m ? s0 : 5'h03, rxd);
        @(posedge clk);
        t <= 1'b1;
        @(negedge clk);
        wait_sig(int'(c), 1'b0, 40, n);
        chk("t_to_drop", 5'h01, 5'(n >= 13 && n <= 28));
        @(posedge clk);
        j <= 1'b0;
        t <= 1'b0;
        repeat (c ? 200 : 20) @(posedge clk);
    endtask : t_rx

    task automatic t_float();
        int n;
        @(posedge clk);
        repeater <= 1'b1;
        repeat (4) @(negedge clk);
        chk("float_off", 5'h01, 5'(oe_n));
        @(posedge clk);
        flt <= 1'b1;
        @(negedge clk);
        wait_sig(5, 1'b0, 8, n);
        chk("float_on", 5'h01, 5'(n >= 1 && n <= 3));
        @(posedge clk);
        repeater <= 1'b0;
        repeat (4) @(negedge clk);
        chk("fifo_room", 5'h01, 5'(rdy));
    endtask : t_float

    initial begin
        fail_count = 0;
        total_checks = 0;
        reset_in = 1'b1;
        {sym_mode, repeater, j, t, strobe, pulse, flt, start} = 8'h00;
        rx_sym = 5'h00;
        len = 4'h4;
        repeat (4) @(posedge clk);
        reset_in <= 1'b0;
        t_link();
        t_tx(1'b1);
        t_tx(1'b0);
        t_rx(1'b0, 1'b0);
        t_rx(1'b1, 1'b0);
        t_rx(1'b0, 1'b1);
        t_float();
        conclude();
    end
endmodule : tb_mpl_top
